/* File: test/sdpi_ctrl_bench.sv */
/*
  Self-checking bench of the DRAM pin controller with a memory model.
  Assumes the monitor and model files are compiled before it.
*/
`timescale 1ns/1ps

module sdpi_ctrl_bench;
  localparam int CAS_LAT = 2;
  logic sys_clk_i, arst_n_i, req_valid_i, req_write_i, wr_valid_i;
  logic refresh_req_i, suspend_i, req_ready_o, wr_ready_o, rd_valid_o;
  logic refresh_ack_o, mem_dq_oe_o, row_strobe_n_o, col_strobe_n_o;
  logic write_en_n_o;
  logic [3:0] req_row_sel_i, mem_addr_b_copy_n_o, mem_addr_c_copy_n_o;
  logic [1:0] req_bank_i, bank_sel_o;
  logic [12:0] req_row_i, mem_addr_a_o, cur_row;
  logic [8:0] req_col_i;
  logic [63:0] wr_data_i, rd_data_o, mem_dq_i, mem_dq_o, d;
  logic [7:0] wr_be_i, dq_mask_o;
  logic [5:0] row_sel_a_n_o, row_sel_b_n_o, mem_clk_en_o;
  logic [31:0] rnd = 32'h4c5b;
  logic [63:0] exp_mem [logic [23:0]];
  logic [23:0] keys [8];
  logic [3:0] cur_sel = 4'h0;
  int num_errors = 0;
  int compares = 0;
  wire [11:0] cs_n = {row_sel_b_n_o, row_sel_a_n_o};
  wire [11:0] exp_cs = ~(12'h1 << cur_sel);

  sdpi_ctrl #(.COL_W(9), .CAS_LAT(CAS_LAT), .FIFO_DEPTH(8)) dut (.*);
  sdpi_mem_model u_mem (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [63:0] merge(input logic [63:0] o, n,
                                        input logic [7:0] be);
    for (int i = 0; i < 8; i++)
      if (be[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction : merge

  task automatic chk_word(input logic [63:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic push(input logic [63:0] v, input logic [7:0] be);
    @(posedge sys_clk_i);
    wr_valid_i <= 1'b1;
    wr_data_i <= v;
    wr_be_i <= be;
    @(negedge sys_clk_i);
    for (int n = 0; n < 50 && wr_ready_o !== 1'b1; n++) @(negedge sys_clk_i);
    chk_flag(wr_ready_o, 1'b1);
    @(posedge sys_clk_i);
    wr_valid_i <= 1'b0;
  endtask : push

  task automatic access(input logic w, input logic [23:0] k,
                        input logic [3:0] sel);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_row_sel_i <= sel;
    {req_bank_i, req_row_i, req_col_i} <= k;
    @(negedge sys_clk_i);
    for (int n = 0; n < 50 && req_ready_o !== 1'b1; n++) @(negedge sys_clk_i);
    chk_flag(req_ready_o, 1'b1);
    @(posedge sys_clk_i);
    cur_sel = sel;
    cur_row = k[21:9];
    req_valid_i <= 1'b0;
    if (!w)
    begin
      for (int n = 0; n < 20 && rd_valid_o !== 1'b1; n++)
        @(negedge sys_clk_i);
      chk_word(rd_data_o, exp_mem[k]);
    end
  endtask : access

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  always @(negedge sys_clk_i)
    if (arst_n_i && !row_strobe_n_o && col_strobe_n_o && write_en_n_o)
    begin
      chk_word(64'(cs_n), 64'(exp_cs));
      chk_word(64'(mem_addr_a_o), 64'(cur_row));
    end

  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    #2000000;
    num_errors++;
    close_out();
  end

  initial
  begin
    {arst_n_i, req_valid_i, req_write_i, wr_valid_i} = 4'h0;
    {refresh_req_i, suspend_i, req_row_sel_i, req_bank_i} = 8'h00;
    {req_row_i, req_col_i, wr_data_i, wr_be_i} = '0;
    repeat (4) @(posedge sys_clk_i);
    chk_word(64'(mem_clk_en_o), 64'h3f);
    chk_word(64'(dq_mask_o), 64'hff);
    arst_n_i <= 1'b1;
    for (int r = 0; r < 6; r++)
    begin
      for (int j = 0; j < 8; j++)
      begin
        rnd = lfsr(rnd);
        keys[j] = (r == 0 && j == 0) ? 24'hffffff : rnd[23:0];
        d = {rnd, lfsr(rnd)};
        exp_mem[keys[j]] = d;
        push(d, 8'hff);
      end
      @(negedge sys_clk_i);
      chk_flag(wr_ready_o, 1'b0);
      for (int j = 0; j < 8; j++)
        access(1'b1, keys[j], 4'((j + r) % 12));
      rnd = lfsr(rnd);
      d = {lfsr(rnd), rnd};
      push(d, rnd[7:0]);
      exp_mem[keys[r]] = merge(exp_mem[keys[r]], d, rnd[7:0]);
      access(1'b1, keys[r], 4'hb);
      for (int j = 0; j < 8; j++)
        access(1'b0, keys[j], 4'(j));
    end
    @(posedge sys_clk_i);
    refresh_req_i <= 1'b1;
    @(negedge sys_clk_i);
    for (int n = 0; n < 20 && refresh_ack_o !== 1'b1; n++)
      @(negedge sys_clk_i);
    chk_flag(refresh_ack_o, 1'b1);
    @(posedge sys_clk_i);
    refresh_req_i <= 1'b0;
    suspend_i <= 1'b1;
    @(negedge sys_clk_i);
    for (int n = 0; n < 20 && mem_clk_en_o !== 6'h00; n++)
      @(negedge sys_clk_i);
    chk_word(64'(mem_clk_en_o), 64'h0);
    chk_flag(req_ready_o, 1'b0);
    @(posedge sys_clk_i);
    suspend_i <= 1'b0;
    @(negedge sys_clk_i);
    for (int n = 0; n < 20 && mem_clk_en_o !== 6'h3f; n++)
      @(negedge sys_clk_i);
    chk_word(64'(mem_clk_en_o), 64'h3f);
    access(1'b0, keys[0], 4'h0);
    close_out();
  end
endmodule : sdpi_ctrl_bench

bind sdpi_ctrl sdpi_ctrl_monitor #(.CAS_LAT(CAS_LAT)) u_mon (.*);

/* File: test/sdpi_ctrl_monitor.sv */
/*
  Concurrent checks on the memory pins of the DRAM pin controller.
  Assumes it is bound to the controller and sees only its ports.
*/
`timescale 1ns/1ps

module sdpi_ctrl_monitor #(
  parameter int CAS_LAT = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Observed outputs
  input wire logic rd_valid_o,
  input wire logic refresh_ack_o,
  input wire logic [12:0] mem_addr_a_o,
  input wire logic [3:0] mem_addr_b_copy_n_o,
  input wire logic [3:0] mem_addr_c_copy_n_o,
  input wire logic [1:0] bank_sel_o,
  input wire logic mem_dq_oe_o,
  input wire logic [7:0] dq_mask_o,
  input wire logic [5:0] row_sel_a_n_o,
  input wire logic [5:0] row_sel_b_n_o,
  input wire logic row_strobe_n_o,
  input wire logic col_strobe_n_o,
  input wire logic write_en_n_o,
  input wire logic [5:0] mem_clk_en_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  localparam int RD_LAT = CAS_LAT + 3;
  wire [2:0] cmd = {row_strobe_n_o, col_strobe_n_o, write_en_n_o};
  wire [11:0] cs_n = {row_sel_b_n_o, row_sel_a_n_o};

  property p_bank_quiet;
    $changed(bank_sel_o) |-> &cs_n;
  endproperty
  a_bank_quiet: assert property (p_bank_quiet) else $error("cs low on bank change");
  property p_copy;
    (mem_addr_b_copy_n_o == ~mem_addr_a_o[7:4])
      && (mem_addr_c_copy_n_o == ~mem_addr_a_o[7:4]);
  endproperty
  a_copy: assert property (p_copy) else $error("address copy wrong");
  property p_act_row;
    cmd == sdpi_pkg::SDPI_CMD_ACT |-> $onehot0(~cs_n);
  endproperty
  a_act_row: assert property (p_act_row) else $error("several rows on activate");
  property p_we;
    !write_en_n_o |-> cmd == sdpi_pkg::SDPI_CMD_WRITE
      || cmd == sdpi_pkg::SDPI_CMD_PRE;
  endproperty
  a_we: assert property (p_we) else $error("write enable outside write");
  property p_wr_drive;
    cmd == sdpi_pkg::SDPI_CMD_WRITE && !(&cs_n) |-> mem_dq_oe_o;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("data not driven");
  property p_rd_mask;
    cmd == sdpi_pkg::SDPI_CMD_READ |-> dq_mask_o == 8'h00;
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("mask set on read");
  property p_rd_lat;
    cmd == sdpi_pkg::SDPI_CMD_READ && !(&cs_n) |-> ##RD_LAT rd_valid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_ack;
    refresh_ack_o |-> cmd == sdpi_pkg::SDPI_CMD_REF && cs_n == 12'h000;
  endproperty
  a_ack: assert property (p_ack) else $error("refresh command wrong");
  property p_cke;
    $fell(mem_clk_en_o[0]) |-> cmd == sdpi_pkg::SDPI_CMD_REF
      && mem_clk_en_o == 6'h00;
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable drop wrong");

  c_rd: cover property (rd_valid_o);
  c_wr: cover property (cmd == sdpi_pkg::SDPI_CMD_WRITE);
  c_ref: cover property (refresh_ack_o);
  c_self: cover property (mem_clk_en_o == 6'h00);
endmodule : sdpi_ctrl_monitor

/* File: test/sdpi_mem_model.sv */
/*
  Behavioural memory array answering the controller pins.
  Assumes CAS latency 2 and the controller clock on the array.
*/
`timescale 1ns/1ps

module sdpi_mem_model (
  // Pins from the controller
  input wire logic sys_clk_i,
  input wire logic row_strobe_n_o,
  input wire logic col_strobe_n_o,
  input wire logic write_en_n_o,
  input wire logic [5:0] row_sel_a_n_o,
  input wire logic [5:0] row_sel_b_n_o,
  input wire logic [1:0] bank_sel_o,
  input wire logic [12:0] mem_addr_a_o,
  input wire logic [63:0] mem_dq_o,
  input wire logic [7:0] dq_mask_o,
  // Read data to the controller
  output logic [63:0] mem_dq_i = 64'h0
);
  logic [63:0] mem [logic [23:0]];
  logic [12:0] open_row [4];
  logic [63:0] word = 64'h0;
  logic [63:0] m;
  logic rd_due = 1'b0;
  wire [2:0] cmd = {row_strobe_n_o, col_strobe_n_o, write_en_n_o};
  wire sel = ~&{row_sel_a_n_o, row_sel_b_n_o};
  wire [23:0] key = {bank_sel_o, open_row[bank_sel_o], mem_addr_a_o[8:0]};

  always @(posedge sys_clk_i)
  begin
    rd_due <= sel && cmd == sdpi_pkg::SDPI_CMD_READ;
    if (sel && cmd == sdpi_pkg::SDPI_CMD_ACT)
      open_row[bank_sel_o] <= mem_addr_a_o;
    if (sel && cmd == sdpi_pkg::SDPI_CMD_READ)
      word <= mem[key];
    if (sel && cmd == sdpi_pkg::SDPI_CMD_WRITE)
    begin
      m = mem.exists(key) ? mem[key] : 64'h0;
      for (int i = 0; i < 8; i++)
        if (!dq_mask_o[i]) m[8*i+:8] = mem_dq_o[8*i+:8];
      mem[key] = m;
    end
    // Outside the read beat the bus shows a changing pattern.
    mem_dq_i <= rd_due ? word : ~mem_dq_i;
  end
endmodule : sdpi_mem_model

/* File: verilog/sdpi_ctrl.sv */
/*
  Controller end of a synchronous DRAM pin interface: one access per
  request with activate, read or write, then precharge; refresh on request
  and self-refresh while suspended. Write data waits in a FIFO.
  Assumes the memory array is clocked by sys_clk_i, and that requests,
  write data and refresh requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "sdpi_defines.svh"

// Notes on behaviour
// - Row address then column address share the address outputs per access.
// - Two bank select lines choose the internal bank for each access.
// - Address plus bank select lines reach every location of a device.
// - All chip selects stay deasserted in any cycle bank select changes.
// - Data moves on a 64-bit two-way bus, driven by us on writes.
// - Eight mask lines: output enables on reads, byte enables on writes.
// - Two groups of six row selects; only the addressed row is selected, all twelve on refresh and self-refresh entry.
// - Row and column strobes drive the array directly from flip-flops.
// - Active-low write enable asserted on writes and precharges, deasserted otherwise.
// - On suspend the six clock enables drop for self-refresh.
module sdpi_ctrl #(
  parameter int COL_W = 9,
  parameter int CAS_LAT = 2,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Access requests
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [3:0] req_row_sel_i,
  input wire logic [1:0] req_bank_i,
  input wire logic [12:0] req_row_i,
  input wire logic [COL_W-1:0] req_col_i,
  // Write data
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [63:0] wr_data_i,
  input wire logic [7:0] wr_be_i,
  // Read data
  output logic rd_valid_o,
  output logic [63:0] rd_data_o,
  // Refresh and suspend
  input wire logic refresh_req_i,
  output logic refresh_ack_o,
  input wire logic suspend_i,
  // Memory pins
  output logic [12:0] mem_addr_a_o,
  output logic [3:0] mem_addr_b_copy_n_o,
  output logic [3:0] mem_addr_c_copy_n_o,
  output logic [1:0] bank_sel_o,
  input wire logic [63:0] mem_dq_i,
  output logic [63:0] mem_dq_o,
  output logic mem_dq_oe_o,
  output logic [7:0] dq_mask_o,
  output logic [5:0] row_sel_a_n_o,
  output logic [5:0] row_sel_b_n_o,
  output logic row_strobe_n_o,
  output logic col_strobe_n_o,
  output logic write_en_n_o,
  output logic [5:0] mem_clk_en_o
);

  if (COL_W < 1 || COL_W > `SDPI_AP_BIT)
  begin : g_bad_col
    $error("sdpi_ctrl: COL_W must be 1 to 10");
  end
  if (CAS_LAT < 1 || CAS_LAT > 3)
  begin : g_bad_cas
    $error("sdpi_ctrl: CAS_LAT must be 1 to 3");
  end

  sdpi_pkg::sdpi_state_t state_reg, state_next;
  sdpi_pkg::sdpi_state_t ret_reg, ret_next;
  sdpi_pkg::sdpi_cmd_t cmd_reg, cmd_next;
  logic [3:0] wait_reg, wait_next;
  logic [11:0] cs_n_reg, cs_n_next;
  logic [12:0] addr_reg, addr_next;
  logic [3:0] addr_b_reg;
  logic [3:0] addr_c_reg;
  logic [1:0] bank_reg, bank_next;
  logic [5:0] cke_reg, cke_next;
  logic dq_oe_reg, dq_oe_next;
  logic [63:0] dq_out_reg, dq_out_next;
  logic [7:0] dqm_reg, dqm_next;
  logic rd_valid_reg, rd_valid_next;
  logic [63:0] rd_data_reg, rd_data_next;
  logic ack_reg, ack_next;
  logic [63:0] dq_s1_reg, dq_s2_reg;
  logic susp_s1_reg, susp_s2_reg;
  logic req_write_reg;
  logic [3:0] req_rsel_reg;
  logic [12:0] req_row_reg;
  logic [COL_W-1:0] req_col_reg;
  logic do_act;
  logic fifo_pop;

  wire fifo_valid;
  wire [71:0] fifo_word;
  wire is_idle = (state_reg == sdpi_pkg::SDPI_IDLE);
  wire wr_data_ok = !req_write_i || fifo_valid;
  assign req_ready_o = is_idle && !susp_s2_reg && !refresh_req_i
                       && wr_data_ok;
  wire take_req = req_ready_o && req_valid_i;
  wire bank_change = (req_bank_i != bank_reg);
  wire [3:0] act_rsel = is_idle ? req_row_sel_i : req_rsel_reg;
  wire [12:0] act_row = is_idle ? req_row_i : req_row_reg;
  wire [11:0] act_cs_n = ~(12'h001 << act_rsel);
  wire [11:0] row_cs_n = ~(12'h001 << req_rsel_reg);
  wire [12:0] col_addr = 13'(req_col_reg);

  sdpi_fifo #(
    .WIDTH(72),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i({wr_be_i, wr_data_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_word)
  );

  always_comb
  begin
    state_next = state_reg;
    ret_next = ret_reg;
    wait_next = wait_reg;
    cmd_next = sdpi_pkg::SDPI_CMD_NOP;
    cs_n_next = `SDPI_CS_NONE;
    addr_next = addr_reg;
    bank_next = bank_reg;
    cke_next = cke_reg;
    dq_oe_next = 1'b0;
    dq_out_next = dq_out_reg;
    dqm_next = `SDPI_DQM_ALL;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    ack_next = 1'b0;
    do_act = 1'b0;
    fifo_pop = 1'b0;
    unique case (state_reg)
      sdpi_pkg::SDPI_IDLE:
      begin
        if (susp_s2_reg)
        begin
          // Self-refresh entry: refresh command with clock enables low.
          cmd_next = sdpi_pkg::SDPI_CMD_REF;
          cs_n_next = `SDPI_CS_ALL;
          cke_next = `SDPI_CKE_OFF;
          state_next = sdpi_pkg::SDPI_SELF;
        end
        else if (refresh_req_i)
        begin
          cmd_next = sdpi_pkg::SDPI_CMD_REF;
          cs_n_next = `SDPI_CS_ALL;
          ack_next = 1'b1;
          wait_next = 4'(`SDPI_T_RFC_CYC - 1);
          ret_next = sdpi_pkg::SDPI_IDLE;
          state_next = sdpi_pkg::SDPI_WAIT;
        end
        else if (take_req)
        begin
          bank_next = req_bank_i;
          if (bank_change)
          begin
            // Chip selects stay high while the new bank settles.
            wait_next = 4'(`SDPI_BANK_SETUP_CYC - 1);
            state_next = sdpi_pkg::SDPI_SETUP;
          end
          else
            do_act = 1'b1;
        end
      end
      sdpi_pkg::SDPI_SETUP:
      begin
        if (wait_reg == 4'h0)
          do_act = 1'b1;
        else
          wait_next = wait_reg - 4'h1;
      end
      sdpi_pkg::SDPI_WAIT:
      begin
        if (wait_reg == 4'h0)
          state_next = ret_reg;
        else
          wait_next = wait_reg - 4'h1;
      end
      sdpi_pkg::SDPI_RW:
      begin
        cs_n_next = row_cs_n;
        addr_next = col_addr;
        if (req_write_reg)
        begin
          cmd_next = sdpi_pkg::SDPI_CMD_WRITE;
          dq_oe_next = 1'b1;
          dq_out_next = fifo_word[63:0];
          dqm_next = ~fifo_word[71:64];
          fifo_pop = 1'b1;
          wait_next = 4'(`SDPI_T_WR_CYC - 1);
          ret_next = sdpi_pkg::SDPI_PRE;
          state_next = sdpi_pkg::SDPI_WAIT;
        end
        else
        begin
          cmd_next = sdpi_pkg::SDPI_CMD_READ;
          dqm_next = `SDPI_DQM_NONE;
          // Data stands CAS_LAT edges after the read, then crosses two flops.
          wait_next = 4'(CAS_LAT + 2);
          state_next = sdpi_pkg::SDPI_CAPT;
        end
      end
      sdpi_pkg::SDPI_CAPT:
      begin
        dqm_next = `SDPI_DQM_NONE;
        if (wait_reg == 4'h0)
        begin
          rd_valid_next = 1'b1;
          rd_data_next = dq_s2_reg;
          state_next = sdpi_pkg::SDPI_PRE;
        end
        else
          wait_next = wait_reg - 4'h1;
      end
      sdpi_pkg::SDPI_PRE:
      begin
        cmd_next = sdpi_pkg::SDPI_CMD_PRE;
        cs_n_next = row_cs_n;
        addr_next = 13'h0000;
        wait_next = 4'(`SDPI_T_RP_CYC - 1);
        ret_next = sdpi_pkg::SDPI_IDLE;
        state_next = sdpi_pkg::SDPI_WAIT;
      end
      sdpi_pkg::SDPI_SELF:
      begin
        if (!susp_s2_reg)
        begin
          cke_next = `SDPI_CKE_ON;
          wait_next = 4'(`SDPI_T_XSR_CYC - 1);
          ret_next = sdpi_pkg::SDPI_IDLE;
          state_next = sdpi_pkg::SDPI_WAIT;
        end
      end
    endcase
    if (do_act)
    begin
      // Activate opens the row; the column follows after the delay.
      cmd_next = sdpi_pkg::SDPI_CMD_ACT;
      cs_n_next = act_cs_n;
      addr_next = act_row;
      wait_next = 4'(`SDPI_T_RCD_CYC - 1);
      ret_next = sdpi_pkg::SDPI_RW;
      state_next = sdpi_pkg::SDPI_WAIT;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= sdpi_pkg::SDPI_IDLE;
      ret_reg <= sdpi_pkg::SDPI_IDLE;
      wait_reg <= 4'h0;
      cmd_reg <= sdpi_pkg::SDPI_CMD_NOP;
      cs_n_reg <= `SDPI_CS_NONE;
      addr_reg <= 13'h0000;
      addr_b_reg <= 4'hf;
      addr_c_reg <= 4'hf;
      bank_reg <= 2'h0;
      cke_reg <= `SDPI_CKE_ON;
    end
    else
    begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      wait_reg <= wait_next;
      cmd_reg <= cmd_next;
      cs_n_reg <= cs_n_next;
      addr_reg <= addr_next;
      addr_b_reg <= ~addr_next[7:4];
      addr_c_reg <= ~addr_next[7:4];
      bank_reg <= bank_next;
      cke_reg <= cke_next;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dq_oe_reg <= 1'b0;
      dq_out_reg <= 64'h0;
      dqm_reg <= `SDPI_DQM_ALL;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 64'h0;
      ack_reg <= 1'b0;
      dq_s1_reg <= 64'h0;
      dq_s2_reg <= 64'h0;
      susp_s1_reg <= 1'b0;
      susp_s2_reg <= 1'b0;
    end
    else
    begin
      dq_oe_reg <= dq_oe_next;
      dq_out_reg <= dq_out_next;
      dqm_reg <= dqm_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      ack_reg <= ack_next;
      dq_s1_reg <= mem_dq_i;
      dq_s2_reg <= dq_s1_reg;
      susp_s1_reg <= suspend_i;
      susp_s2_reg <= susp_s1_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      req_write_reg <= 1'b0;
      req_rsel_reg <= 4'h0;
      req_row_reg <= 13'h0000;
      req_col_reg <= '0;
    end
    else if (take_req)
    begin
      req_write_reg <= req_write_i;
      req_rsel_reg <= req_row_sel_i;
      req_row_reg <= req_row_i;
      req_col_reg <= req_col_i;
    end
  end

  assign mem_addr_a_o = addr_reg;
  assign mem_addr_b_copy_n_o = addr_b_reg;
  assign mem_addr_c_copy_n_o = addr_c_reg;
  assign bank_sel_o = bank_reg;
  assign mem_dq_o = dq_out_reg;
  assign mem_dq_oe_o = dq_oe_reg;
  assign dq_mask_o = dqm_reg;
  assign row_sel_a_n_o = cs_n_reg[5:0];
  assign row_sel_b_n_o = cs_n_reg[11:6];
  assign row_strobe_n_o = cmd_reg[2];
  assign col_strobe_n_o = cmd_reg[1];
  assign write_en_n_o = cmd_reg[0];
  assign mem_clk_en_o = cke_reg;
  assign rd_valid_o = rd_valid_reg;
  assign rd_data_o = rd_data_reg;
  assign refresh_ack_o = ack_reg;

endmodule : sdpi_ctrl

/* File: verilog/sdpi_defines.svh */
/*
  Constants of the synchronous DRAM pin interface: clock rate, timing
  figures and the cycle counts derived from them, and reset values of the
  memory pins. Assumes the controller clock also clocks the memory array.
*/
`ifndef SDPI_DEFINES_SVH
`define SDPI_DEFINES_SVH

`define SDPI_CLK_MHZ 10
// Least time in ns rounded up to whole controller cycles.
`define SDPI_CYC(ns) ((((ns) * `SDPI_CLK_MHZ) + 999) / 1000)

`define SDPI_T_RCD_NS 20
`define SDPI_T_RP_NS 20
`define SDPI_T_WR_NS 15
`define SDPI_T_RFC_NS 70
`define SDPI_T_XSR_NS 80

`define SDPI_T_RCD_CYC `SDPI_CYC(`SDPI_T_RCD_NS)
`define SDPI_T_RP_CYC `SDPI_CYC(`SDPI_T_RP_NS)
`define SDPI_T_WR_CYC `SDPI_CYC(`SDPI_T_WR_NS)
`define SDPI_T_RFC_CYC `SDPI_CYC(`SDPI_T_RFC_NS)
`define SDPI_T_XSR_CYC `SDPI_CYC(`SDPI_T_XSR_NS)

`define SDPI_BANK_SETUP_CYC 2
`define SDPI_AP_BIT 10
`define SDPI_CS_NONE 12'hfff
`define SDPI_CS_ALL 12'h000
`define SDPI_CKE_ON 6'h3f
`define SDPI_CKE_OFF 6'h00
`define SDPI_DQM_ALL 8'hff
`define SDPI_DQM_NONE 8'h00

`endif

/* File: verilog/sdpi_fifo.sv */
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps

module sdpi_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_param
    $error("sdpi_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_i;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule : sdpi_fifo

/* File: verilog/sdpi_pkg.sv */
/*
  Types of the synchronous DRAM pin interface: controller states and the
  command code on row strobe, column strobe and write enable.
  Assumes the defines header supplies all numeric constants.
*/
package sdpi_pkg;

  typedef enum logic [1:0] {
    SDPI_ST_IDLE_UNUSED
  } sdpi_unused_t;

  typedef enum {
    SDPI_IDLE,
    SDPI_SETUP,
    SDPI_WAIT,
    SDPI_RW,
    SDPI_CAPT,
    SDPI_PRE,
    SDPI_SELF
  } sdpi_state_t;

  // Active-low levels of {row strobe, column strobe, write enable}.
  typedef enum logic [2:0] {
    SDPI_CMD_NOP = 3'h7,
    SDPI_CMD_ACT = 3'h3,
    SDPI_CMD_READ = 3'h5,
    SDPI_CMD_WRITE = 3'h4,
    SDPI_CMD_PRE = 3'h2,
    SDPI_CMD_REF = 3'h1
  } sdpi_cmd_t;

endpackage : sdpi_pkg
